// ===== cqsp_card.sv
/*
  behavioural managed card on the command line: answers a queue status command
  lat cycles later with a queue status word (no answer when lat is zero),
  and sends other responses on request.
  assumes the host clock and a synchronous reset; latency is set by the bench.
*/
`timescale 1ns/10ps
`default_nettype none
module cqsp_card
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        srst,
  // status command from the host and reply control
  input  wire logic        qsc_req,
  input  wire logic [31:0] queue_status_word,
  input  wire logic [3:0]  lat,
  // other responses on request
  input  wire logic        go,
  input  wire logic [5:0]  go_idx,
  input  wire logic [31:0] go_arg,
  input  wire logic        go_r1,
  // response to the host
  output logic             rsp_valid,
  output logic      [5:0]  rsp_index,
  output logic      [31:0] rsp_arg,
  output logic             rsp_is_r1
);
  logic [3:0] dly;
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      dly       <= 4'h0;
      rsp_valid <= 1'b0;
      rsp_index <= 6'h00;
      rsp_arg   <= 32'h0;
      rsp_is_r1 <= 1'b0;
    end
    else
    begin
      // idle lines never hold the last value, so a stale read cannot pass
      rsp_valid <= 1'b0;
      rsp_index <= ~rsp_index;
      rsp_arg   <= ~rsp_arg;
      rsp_is_r1 <= ~rsp_is_r1;
      if (dly != 4'h0)
        dly <= dly - 4'h1;
      if (qsc_req)
        dly <= lat;
      if (dly == 4'h1)
        {rsp_valid, rsp_index, rsp_arg, rsp_is_r1} <= {1'b1, 6'h0D, queue_status_word, 1'b1};
      else if (go)
        {rsp_valid, rsp_index, rsp_arg, rsp_is_r1} <= {1'b1, go_idx, go_arg, go_r1};
    end
  end
endmodule : cqsp_card
`default_nettype wire

// ===== cqsp_pkg.sv
/*
  constants for the queue status poll and error capture block: register offsets,
  field positions, reset values, command indexes.
  assumes byte addressing with one aligned 32-bit word per register.
*/
`default_nettype none
package cqsp_pkg;
  // register byte offsets
  localparam logic [11:0] OFS_POLL_CFG  = 12'h240;
  localparam logic [11:0] OFS_POLL_RCA  = 12'h244;
  localparam logic [11:0] OFS_DIRECT_COMMAND_TASK_RSP  = 12'h248;
  localparam logic [11:0] OFS_ERR_MASK  = 12'h250;
  localparam logic [11:0] OFS_TASK_ERR  = 12'h254;
  localparam logic [11:0] OFS_LAST_IDX  = 12'h258;
  localparam logic [11:0] OFS_LAST_ARG  = 12'h25C;
  localparam logic [11:0] OFS_INT_STS   = 12'h260;
  localparam logic [11:0] OFS_INT_MASK  = 12'h264;
  // field positions
  localparam int          POS_BLK_CNT   = 16;
  localparam int          POS_RCA_ARG   = 16;
  localparam int          POS_DATA_IDX  = 16;
  localparam int          POS_ERR_VALID = 15;
  localparam int          POS_ERR_TID   = 8;
  // reset values
  localparam logic [3:0]  RST_BLK_CNT   = 4'h1;
  localparam logic [15:0] RST_IDLE_TMR  = 16'h1000;
  localparam logic [31:0] RST_ERR_MASK  = 32'hFDF9A080;
  // command indexes and slots
  localparam logic [5:0]  IDX_QSTATUS   = 6'h0D;
  localparam logic [5:0]  IDX_EXEC_RD   = 6'h2E;
  localparam logic [5:0]  IDX_EXEC_WR   = 6'h2F;
  localparam logic [4:0]  DIRECT_COMMAND_TASK_SLOT     = 5'h1F;
  // interrupt status bits
  localparam int          INT_RSP_ERR   = 0;
  localparam int          INT_ERR_CAP   = 1;
  localparam int          INT_BITS      = 2;
endpackage : cqsp_pkg
`default_nettype wire

// ===== cqsp_top.sv
/*
  queue status poll scheduling, response recording and error capture for a
  command queueing engine.
  assumes the engine's command and data sequencers run on the same clock and
  give one-cycle pulses; the timer clock arrives from another domain.
*/
// The strobed register port was decided locally.
//
// How it works
// - status command during block count minus n
// - field zero: status only while data idle
// - field one: status during last block
// - no ready task: wait idle interval, repoll
// - idle timer counts timer clock periods, 1..65535
// - default interval 4096 timer clock periods
// - card address goes to argument bits 31:16
// - direct command response loaded; valid after doorbell clears
// - masked set status bits raise response error
// - queue status responses skip the mask check
// - data error records read/write execute index
// - error valid set iff command in progress
// - capture task id on command line
// - capture command index on command line
// - last response index overwritten per response
// - last response argument overwritten per response
// - direct command task lives in slot 31
`timescale 1ns/10ps
`default_nettype none
module cqsp_top
  import cqsp_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        srst,
  // register port
  input  wire logic [11:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // timer clock from the other domain
  input  wire logic        timer_clk,
  // engine state
  input  wire logic        direct_command_task_en,
  input  wire logic        tasks_pending,
  input  wire logic        cmd_busy,
  input  wire logic        xfer_active,
  input  wire logic        xfer_write,
  input  wire logic [15:0] xfer_blocks,
  input  wire logic [15:0] xfer_cur_block,
  // command line activity
  input  wire logic        cmd_active,
  input  wire logic [4:0]  cmd_task_id,
  input  wire logic [5:0]  cmd_index,
  // responses
  input  wire logic        rsp_valid,
  input  wire logic [5:0]  rsp_index,
  input  wire logic [31:0] rsp_arg,
  input  wire logic        rsp_is_r1,
  // errors
  input  wire logic        err_event,
  // status command request and interrupt
  output logic             qsc_req,
  output logic      [31:0] qsc_arg,
  output logic             irq
);

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WAIT  = 2'b01,
    ST_COUNT = 2'b10
  } cqsp_st_t;

  typedef struct packed {
    logic [3:0]          blk_cnt;
    logic [15:0]         idle_tmr;
    logic [15:0]         rca;
    logic [31:0]         direct_command_task_rsp;
    logic [5:0]          data_idx;
    logic                err_valid;
    logic [4:0]          err_tid;
    logic [5:0]          err_cidx;
    logic [5:0]          last_idx;
    logic [31:0]         last_arg;
    logic [INT_BITS-1:0] int_sts;
    logic [INT_BITS-1:0] int_msk;
    logic                irq;
    logic [31:0]         rdata;
    logic                qsc_req;
    logic [31:0]         qsc_arg;
    cqsp_st_t            st;
    logic [15:0]         tmr;
    logic                poll_due;
    logic                xfer_sent;
    logic                xfer_prev;
    logic                pend_prev;
    logic [2:0]          tsync;
    logic                tlvl;
  } cqsp_state_t;

  cqsp_state_t r_reg;
  cqsp_state_t r_next;

  logic        tick;
  logic        xfer_hit;
  logic        idle_ok;
  logic        issue;
  logic        rsp_err;
  logic [15:0] tmr_limit;
  logic [31:0] rd_word;
  logic [INT_BITS-1:0] ev;

  always_comb
  begin
    // a timer period counts once the second and third stages agree on a high
    tick      = (r_reg.tsync[2] == r_reg.tsync[1]) && r_reg.tsync[1] && !r_reg.tlvl;
    tmr_limit = (r_reg.idle_tmr == 16'h0000) ? 16'h0001 : r_reg.idle_tmr;
    // block count minus n, with blocks counted from zero
    xfer_hit  = xfer_active && (r_reg.blk_cnt != 4'h0)
              && (xfer_blocks >= {12'h000, r_reg.blk_cnt})
              && (xfer_cur_block == xfer_blocks - {12'h000, r_reg.blk_cnt});
    idle_ok   = !xfer_active && tasks_pending;
    issue     = 1'b0;
    if (!cmd_busy && r_reg.st == ST_IDLE)
    begin
      issue = (xfer_hit && !r_reg.xfer_sent) || (idle_ok && r_reg.poll_due);
    end
    else if (!cmd_busy && r_reg.st == ST_COUNT)
    begin
      issue = idle_ok && tick && (r_reg.tmr + 16'h0001 >= tmr_limit);
    end
    // queue status replies carry no device status
    rsp_err = rsp_valid && rsp_is_r1 && (rsp_index != IDX_QSTATUS)
            && |(rsp_arg & RST_ERR_MASK);
    ev = '0;
    ev[INT_RSP_ERR] = rsp_err;
    ev[INT_ERR_CAP] = err_event;

    case (reg_addr)
      OFS_POLL_CFG: rd_word = {12'h000, r_reg.blk_cnt, r_reg.idle_tmr};
      OFS_POLL_RCA: rd_word = {16'h0000, r_reg.rca};
      OFS_DIRECT_COMMAND_TASK_RSP: rd_word = r_reg.direct_command_task_rsp;
      OFS_ERR_MASK: rd_word = RST_ERR_MASK;
      OFS_TASK_ERR: rd_word = {10'h000, r_reg.data_idx, r_reg.err_valid, 2'h0,
                               r_reg.err_tid, 2'h0, r_reg.err_cidx};
      OFS_LAST_IDX: rd_word = {26'h0000000, r_reg.last_idx};
      OFS_LAST_ARG: rd_word = r_reg.last_arg;
      OFS_INT_STS:  rd_word = {{(32-INT_BITS){1'b0}}, r_reg.int_sts};
      OFS_INT_MASK: rd_word = {{(32-INT_BITS){1'b0}}, r_reg.int_msk};
      default:      rd_word = 32'h00000000;
    endcase

    r_next = r_reg;
    r_next.tsync     = {r_reg.tsync[1:0], timer_clk};
    if (r_reg.tsync[2] == r_reg.tsync[1])
    begin
      r_next.tlvl = r_reg.tsync[1];
    end
    r_next.xfer_prev = xfer_active;
    r_next.pend_prev = tasks_pending;
    r_next.rdata     = reg_rd ? rd_word : 32'h00000000;
    r_next.qsc_req   = issue;
    if (issue)
    begin
      r_next.qsc_arg = {r_reg.rca, 16'h0000};
    end

    // an ended transfer or new pending work rearms the idle poll
    if (!xfer_active)
    begin
      r_next.xfer_sent = 1'b0;
    end
    if ((r_reg.xfer_prev && !xfer_active) || (tasks_pending && !r_reg.pend_prev))
    begin
      r_next.poll_due = 1'b1;
    end

    case (r_reg.st)
      ST_IDLE:
      begin
        if (issue)
        begin
          r_next.st       = ST_WAIT;
          r_next.poll_due = 1'b0;
          if (xfer_active)
          begin
            r_next.xfer_sent = 1'b1;
          end
        end
      end
      ST_WAIT:
      begin
        if (rsp_valid && rsp_index == IDX_QSTATUS)
        begin
          r_next.tmr = 16'h0000;
          if (rsp_arg == 32'h00000000 && idle_ok)
          begin
            r_next.st = ST_COUNT;
          end
          else
          begin
            r_next.st = ST_IDLE;
          end
        end
      end
      ST_COUNT:
      begin
        if (!idle_ok)
        begin
          r_next.st       = ST_IDLE;
          r_next.poll_due = 1'b1;
        end
        else if (issue)
        begin
          r_next.st = ST_WAIT;
        end
        else if (tick)
        begin
          r_next.tmr = r_reg.tmr + 16'h0001;
        end
      end
      default:
      begin
        r_next.st = ST_IDLE;
      end
    endcase

    if (rsp_valid)
    begin
      r_next.last_idx = rsp_index;
      r_next.last_arg = rsp_arg;
      // the direct command task always sits in the top doorbell slot
      if (direct_command_task_en && cmd_task_id == DIRECT_COMMAND_TASK_SLOT)
      begin
        r_next.direct_command_task_rsp = rsp_arg;
      end
    end

    // snapshot only on an error so service code reads a stable set
    if (err_event)
    begin
      if (xfer_active)
      begin
        r_next.data_idx = xfer_write ? IDX_EXEC_WR : IDX_EXEC_RD;
      end
      r_next.err_valid = cmd_active;
      if (cmd_active)
      begin
        r_next.err_tid  = cmd_task_id;
        r_next.err_cidx = cmd_index;
      end
    end

    if (reg_wr)
    begin
      case (reg_addr)
        OFS_POLL_CFG:
        begin
          r_next.blk_cnt  = reg_wdata[POS_BLK_CNT +: 4];
          r_next.idle_tmr = reg_wdata[15:0];
        end
        OFS_POLL_RCA: r_next.rca     = reg_wdata[15:0];
        OFS_INT_MASK: r_next.int_msk = reg_wdata[INT_BITS-1:0];
        OFS_INT_STS:  r_next.int_sts = r_reg.int_sts & ~reg_wdata[INT_BITS-1:0];
        default:      r_next.rca     = r_next.rca;
      endcase
    end
    // a new event beats a clear in the same cycle
    r_next.int_sts = r_next.int_sts | ev;
    r_next.irq     = |(r_next.int_sts & r_next.int_msk);

    if (srst)
    begin
      r_next          = '0;
      r_next.st       = ST_IDLE;
      r_next.blk_cnt  = RST_BLK_CNT;
      r_next.idle_tmr = RST_IDLE_TMR;
    end
  end

  always_ff @(posedge clock)
  begin
    r_reg <= r_next;
  end

  assign reg_rdata = r_reg.rdata;
  assign qsc_req   = r_reg.qsc_req;
  assign qsc_arg   = r_reg.qsc_arg;
  assign irq       = r_reg.irq;

  property p_xfer_issue;
    @(posedge clock) disable iff (srst)
    (xfer_hit && !r_reg.xfer_sent && !cmd_busy && r_reg.st == ST_IDLE) |=> qsc_req;
  endproperty
  a_xfer_issue: assert property (p_xfer_issue)
    else $error("status command missed its data block");

  property p_no_xfer_issue;
    @(posedge clock) disable iff (srst)
    (r_reg.blk_cnt == 4'h0 && xfer_active) |=> !qsc_req;
  endproperty
  a_no_xfer_issue: assert property (p_no_xfer_issue)
    else $error("status command sent during a transfer with counter zero");

  property p_last_block;
    @(posedge clock) disable iff (srst)
    (qsc_req && $past(xfer_active) && $past(r_reg.blk_cnt) == 4'h1)
      |-> ($past(xfer_cur_block) == $past(xfer_blocks) - 16'h0001);
  endproperty
  a_last_block: assert property (p_last_block)
    else $error("counter one issued outside the last block");

  property p_idle_wait;
    @(posedge clock) disable iff (srst)
    (r_reg.st == ST_COUNT && !tick) |=> !qsc_req;
  endproperty
  a_idle_wait: assert property (p_idle_wait)
    else $error("poll issued before the idle interval ran out");

  property p_rca_arg;
    @(posedge clock) disable iff (srst)
    qsc_req |-> (qsc_arg == {$past(r_reg.rca), 16'h0000});
  endproperty
  a_rca_arg: assert property (p_rca_arg)
    else $error("card address not in argument upper half");

  property p_rsp_err;
    @(posedge clock) disable iff (srst)
    (rsp_valid && rsp_is_r1 && rsp_index != IDX_QSTATUS && |(rsp_arg & RST_ERR_MASK))
      |=> r_reg.int_sts[INT_RSP_ERR] && (irq || !r_reg.int_msk[INT_RSP_ERR]);
  endproperty
  a_rsp_err: assert property (p_rsp_err)
    else $error("masked device status did not raise response error");

  property p_qs_skip;
    @(posedge clock) disable iff (srst)
    (rsp_valid && rsp_index == IDX_QSTATUS && !r_reg.int_sts[INT_RSP_ERR])
      |=> !r_reg.int_sts[INT_RSP_ERR];
  endproperty
  a_qs_skip: assert property (p_qs_skip)
    else $error("queue status reply raised response error");

  property p_err_valid;
    @(posedge clock) disable iff (srst)
    err_event |=> (r_reg.err_valid == $past(cmd_active));
  endproperty
  a_err_valid: assert property (p_err_valid)
    else $error("error valid flag does not follow command activity");

  // the snapshot must follow the transfer direction seen with the error
  property p_data_idx;
    @(posedge clock) disable iff (srst)
    (err_event && xfer_active)
      |=> (r_reg.data_idx == ($past(xfer_write) ? IDX_EXEC_WR : IDX_EXEC_RD));
  endproperty
  a_data_idx: assert property (p_data_idx)
    else $error("data error command index does not match direction");

  property p_cmd_snap;
    @(posedge clock) disable iff (srst)
    (err_event && cmd_active) |=> (r_reg.err_tid == $past(cmd_task_id))
      && (r_reg.err_cidx == $past(cmd_index));
  endproperty
  a_cmd_snap: assert property (p_cmd_snap)
    else $error("command line snapshot not captured");

  property p_last_rsp;
    @(posedge clock) disable iff (srst)
    rsp_valid |=> (r_reg.last_idx == $past(rsp_index)) && (r_reg.last_arg == $past(rsp_arg));
  endproperty
  a_last_rsp: assert property (p_last_rsp)
    else $error("last response not recorded");

  property p_err_hold;
    @(posedge clock) disable iff (srst)
    !err_event |=> $stable(r_reg.err_valid) && $stable(r_reg.err_tid)
      && $stable(r_reg.err_cidx) && $stable(r_reg.data_idx);
  endproperty
  a_err_hold: assert property (p_err_hold)
    else $error("error snapshot changed without an error");

endmodule : cqsp_top
`default_nettype wire

// ===== tb.sv
/*
  self-checking bench: register tasks, status poll timing, block counter,
  responses, interrupt and error capture.
  assumes a 200 MHz clock and a free running 48 ns timer clock.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) \
  begin \
    n_checks++; \
    if ((g) !== (e)) \
      $display("wrong value at %0t: got %h exp %h", $time, g, e); \
    if ((g) !== (e)) \
      error_cnt++; \
  end
module tb;
  import cqsp_pkg::*;
  logic        clock, srst, reg_wr, reg_rd, timer_clk, direct_command_task_en, tasks_pending;
  logic        cmd_busy, xfer_active, xfer_write, cmd_active, err_event, go;
  logic        go_r1, rsp_valid, rsp_is_r1, qsc_req, irq;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, qsc_arg, rsp_arg, queue_status_word, go_arg, rd_d;
  logic [15:0] xfer_blocks, xfer_cur_block, req_blk;
  logic [5:0]  cmd_index, rsp_index, go_idx;
  logic [4:0]  cmd_task_id;
  logic [3:0]  lat;
  int          error_cnt, n_checks, req_cnt, c, gap;
  time         t_prev, t_last;
  cqsp_top dut (.clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_clk(timer_clk),
    .direct_command_task_en(direct_command_task_en), .tasks_pending(tasks_pending), .cmd_busy(cmd_busy),
    .xfer_active(xfer_active), .xfer_write(xfer_write), .xfer_blocks(xfer_blocks),
    .xfer_cur_block(xfer_cur_block), .cmd_active(cmd_active), .cmd_task_id(cmd_task_id),
    .cmd_index(cmd_index), .rsp_valid(rsp_valid), .rsp_index(rsp_index),
    .rsp_arg(rsp_arg), .rsp_is_r1(rsp_is_r1), .err_event(err_event),
    .qsc_req(qsc_req), .qsc_arg(qsc_arg), .irq(irq));
  cqsp_card card (.clock(clock), .srst(srst), .qsc_req(qsc_req), .queue_status_word(queue_status_word), .lat(lat),
    .go(go), .go_idx(go_idx), .go_arg(go_arg), .go_r1(go_r1), .rsp_valid(rsp_valid),
    .rsp_index(rsp_index), .rsp_arg(rsp_arg), .rsp_is_r1(rsp_is_r1));
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial
  begin
    timer_clk = 1'b0;
    forever #24 timer_clk = ~timer_clk;
  end
  // status command log: count, block moving at issue, issue times
  always @(posedge clock)
    if (qsc_req === 1'b1)
    begin
      req_cnt++;
      req_blk = xfer_cur_block;
      t_prev = t_last;
      t_last = $time;
    end
  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  task chk_rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge clock);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 rd_d = reg_rdata;
    `CHK(rd_d, e)
  endtask : chk_rd
  task send(input logic [5:0] i, input logic [31:0] a, input logic r1);
    @(posedge clock);
    {go, go_idx, go_arg, go_r1} <= {1'b1, i, a, r1};
    @(posedge clock);
    go <= 1'b0;
    repeat (3) @(posedge clock);
  endtask : send
  task err;
    @(posedge clock);
    err_event <= 1'b1;
    @(posedge clock);
    err_event <= 1'b0;
    repeat (2) @(posedge clock);
  endtask : err
  task wait_cnt(input int k);
    for (int i = 0; i < 3000 && req_cnt < k; i++)
      @(posedge clock);
    if (req_cnt < k)
    begin
      error_cnt++;
      $display("wrong value at %0t: status command missing", $time);
      end_of_test();
    end
  endtask : wait_cnt
  initial
  begin
    {srst, reg_wr, reg_rd, direct_command_task_en, tasks_pending, cmd_busy, xfer_active} = 7'h01 << 6;
    {xfer_write, cmd_active, err_event, go, go_r1} = 5'h00;
    {reg_addr, reg_wdata, xfer_blocks, xfer_cur_block, queue_status_word, go_arg} = '0;
    {cmd_index, go_idx, cmd_task_id, lat} = '0;
    {error_cnt, n_checks} = '0;
    repeat (5) @(posedge clock);
    srst <= 1'b0;
    chk_rd(OFS_POLL_CFG, 32'h00011000);
    chk_rd(OFS_ERR_MASK, 32'hFDF9A080);
    wr(OFS_ERR_MASK, 32'h0);
    chk_rd(OFS_ERR_MASK, 32'hFDF9A080);
    chk_rd(OFS_DIRECT_COMMAND_TASK_RSP, 32'h0);
    chk_rd(OFS_LAST_ARG, 32'h0);
    chk_rd(12'h300, 32'h0);
    $display("test reset values done");
    lat <= 4'h1;
    wr(OFS_POLL_RCA, 32'h0000ABCD);
    for (int j = 0; j < 2; j++)
    begin
      wr(OFS_POLL_CFG, {16'h0001, (j != 0) ? 16'h0004 : 16'h0001});
      queue_status_word <= 32'h0;
      tasks_pending <= 1'b1;
      wait_cnt(req_cnt + 3);
      gap = int'(t_last - t_prev);
      c = j ? 4 : 1;
      `CHK(gap >= (c - 1) * 48 && gap <= (c + 1) * 48 + 60, 1'b1)
      `CHK(qsc_arg, 32'hABCD0000)
      queue_status_word <= 32'h00000080;
      repeat (100) @(posedge clock);
      c = req_cnt;
      repeat (200) @(posedge clock);
      `CHK(req_cnt, c)
      tasks_pending <= 1'b0;
    end
    chk_rd(OFS_INT_STS, 32'h0);
    $display("test status polling done");
    lat <= 4'h9;
    for (int n = 2; n >= 0; n--)
    begin
      wr(OFS_POLL_CFG, {12'h000, 4'(n), 16'h0004});
      c = req_cnt;
      {xfer_blocks, xfer_active} <= {16'h5, 1'b1};
      for (int b = 0; b < 5; b++)
      begin
        xfer_cur_block <= 16'(b);
        repeat (20) @(posedge clock);
      end
      xfer_active <= 1'b0;
      repeat (20) @(posedge clock);
      `CHK(req_cnt - c, int'(n != 0))
      if (n != 0)
        `CHK(req_blk, 16'(5 - n))
    end
    $display("test block counter done");
    wr(OFS_INT_MASK, 32'h1);
    send(6'h06, 32'h00000080, 1'b1);
    chk_rd(OFS_LAST_IDX, 32'h06);
    chk_rd(OFS_LAST_ARG, 32'h80);
    chk_rd(OFS_INT_STS, 32'h1);
    `CHK(irq, 1'b1)
    wr(OFS_INT_STS, 32'h1);
    send(6'h11, 32'h00000001, 1'b1);
    chk_rd(OFS_INT_STS, 32'h0);
    `CHK(irq, 1'b0)
    chk_rd(OFS_LAST_IDX, 32'h11);
    wr(OFS_INT_MASK, 32'h0);
    send(6'h06, 32'h00000080, 1'b1);
    `CHK(irq, 1'b0)
    wr(OFS_INT_STS, 32'h1);
    {direct_command_task_en, cmd_task_id} <= {1'b1, DIRECT_COMMAND_TASK_SLOT};
    send(6'h05, 32'h12345678, 1'b0);
    chk_rd(OFS_DIRECT_COMMAND_TASK_RSP, 32'h12345678);
    cmd_task_id <= 5'h03;
    send(6'h05, 32'hDEAD0000, 1'b0);
    chk_rd(OFS_DIRECT_COMMAND_TASK_RSP, 32'h12345678);
    $display("test responses done");
    {xfer_active, xfer_write, cmd_active, cmd_task_id, cmd_index} <= {3'h7, 5'h05, 6'h2C};
    err();
    chk_rd(OFS_TASK_ERR, 32'h002F852C);
    {xfer_active, xfer_write, cmd_active, cmd_task_id, cmd_index} <= {3'h4, 5'h07, 6'h01};
    err();
    chk_rd(OFS_TASK_ERR, 32'h002E052C);
    {xfer_active, xfer_write, cmd_active, cmd_task_id, cmd_index} <= {3'h1, 5'h09, 6'h03};
    err();
    chk_rd(OFS_TASK_ERR, 32'h002E8903);
    chk_rd(OFS_INT_STS, 32'h2);
    $display("test error capture done");
    end_of_test();
  end
endmodule : tb
`default_nettype wire
